// ==== verilog/uep_ctrl.sv ====
// Host-side controller that reads, programs and verifies a 2048 x 8 UV EPROM.
// Assumes the EPROM pins are wired directly, and that vpp_high_o drives a supply switch.
module uep_ctrl #(
  parameter int unsigned PULSE_CYC = uep_pkg::PULSE_NOM_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic      [10:0] word_address_lines_o,
  input  wire logic [7:0]  mem_data_i,
  output logic      [7:0]  mem_data_o,
  output logic             mem_data_oe_o,
  output logic             select_program_strobe_o,
  output logic             gate_n_o,
  output logic             vpp_high_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_RSETUP, ST_RWAIT, ST_PSETUP, ST_PULSE, ST_PHOLD}
    uep_state_t;

  uep_state_t  state_r;
  logic [20:0] cnt_r;
  logic [10:0] addr_r;
  logic [7:0]  wdata_r;
  logic [7:0]  rdata_r;
  logic [1:0]  cmd_r;
  logic        hv_req_r;
  logic        mism_r;
  logic        refuse_r;
  logic        zero_r;
  logic        go;
  logic [1:0]  go_cmd;
  logic        cnt_done;

  assign go       = reg_wr_i && reg_addr_i == uep_pkg::REG_CTRL && reg_wdata_i[uep_pkg::CTRL_GO_BIT];
  assign go_cmd   = reg_wdata_i[uep_pkg::CTRL_CMD_LSB +: 2];
  assign cnt_done = cnt_r == 21'h000000;

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr_r   <= uep_pkg::RST_ADDR;
      wdata_r  <= uep_pkg::RST_DATA;
      hv_req_r <= 1'b0;
    end else if (ce_i && reg_wr_i && state_r == ST_IDLE) begin
      unique case (reg_addr_i)
        uep_pkg::REG_CTRL:  hv_req_r <= reg_wdata_i[uep_pkg::CTRL_HV_BIT];
        uep_pkg::REG_ADDR:  addr_r   <= {addr_r[10:8], reg_wdata_i};
        uep_pkg::REG_WDATA: wdata_r  <= reg_wdata_i;
        uep_pkg::REG_STATUS: addr_r  <= {reg_wdata_i[2:0], addr_r[7:0]};
        default: ;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 21'h000000;
      cmd_r    <= uep_pkg::CMD_READ;
      rdata_r  <= uep_pkg::RST_DATA;
      mism_r   <= 1'b0;
      refuse_r <= 1'b0;
      zero_r   <= 1'b0;
    end else if (ce_i) begin
      unique case (state_r)
        ST_IDLE: begin
          if (go) begin
            cmd_r <= go_cmd;
            if (go_cmd == uep_pkg::CMD_PROGRAM && !hv_req_r) begin
              refuse_r <= 1'b1;
            end else if (go_cmd == uep_pkg::CMD_PROGRAM) begin
              refuse_r <= 1'b0;
              zero_r   <= (rdata_r & ~wdata_r) != 8'h00;
              cnt_r    <= 21'(uep_pkg::SETUP_CYC);
              state_r  <= ST_PSETUP;
            end else begin
              refuse_r <= 1'b0;
              cnt_r    <= 21'(uep_pkg::ACCESS_CYC);
              state_r  <= ST_RSETUP;
            end
          end
        end
        ST_RSETUP: begin
          cnt_r   <= 21'(uep_pkg::ACCESS_CYC);
          state_r <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if (cnt_done) begin
            rdata_r <= mem_data_i;
            mism_r  <= cmd_r == uep_pkg::CMD_VERIFY && mem_data_i != wdata_r;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 21'h000001;
          end
        end
        ST_PSETUP: begin
          if (cnt_done) begin
            cnt_r   <= 21'(PULSE_CYC - 1);
            state_r <= ST_PULSE;
          end else begin
            cnt_r <= cnt_r - 21'h000001;
          end
        end
        ST_PULSE: begin
          if (cnt_done) begin
            cnt_r   <= 21'(uep_pkg::SETUP_CYC);
            state_r <= ST_PHOLD;
          end else begin
            cnt_r <= cnt_r - 21'h000001;
          end
        end
        ST_PHOLD: begin
          if (cnt_done) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 21'h000001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Pin drive
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_address_lines_o    <= uep_pkg::RST_ADDR;
      mem_data_o              <= uep_pkg::RST_DATA;
      mem_data_oe_o           <= 1'b0;
      select_program_strobe_o <= 1'b1;
      gate_n_o                <= 1'b1;
      vpp_high_o              <= 1'b0;
    end else if (ce_i) begin
      word_address_lines_o <= addr_r;
      mem_data_o           <= wdata_r;
      vpp_high_o           <= hv_req_r;
      unique case (state_r)
        ST_RSETUP, ST_RWAIT: begin
          mem_data_oe_o           <= 1'b0;
          select_program_strobe_o <= 1'b0;
          gate_n_o                <= 1'b0;
        end
        ST_PSETUP, ST_PHOLD: begin
          mem_data_oe_o           <= 1'b1;
          select_program_strobe_o <= 1'b0;
          gate_n_o                <= 1'b1;
        end
        ST_PULSE: begin
          mem_data_oe_o           <= 1'b1;
          select_program_strobe_o <= 1'b1;
          gate_n_o                <= 1'b1;
        end
        default: begin
          mem_data_oe_o           <= 1'b0;
          select_program_strobe_o <= !hv_req_r;
          gate_n_o                <= 1'b1;
        end
      endcase
    end
  end

  // Register reads
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      unique case (reg_addr_i)
        uep_pkg::REG_CTRL:   reg_rdata_o <= {4'h0, hv_req_r, cmd_r, 1'b0};
        uep_pkg::REG_ADDR:   reg_rdata_o <= addr_r[7:0];
        uep_pkg::REG_WDATA:  reg_rdata_o <= wdata_r;
        uep_pkg::REG_STATUS: reg_rdata_o <= {3'h0, zero_r, refuse_r, mism_r, vpp_high_o,
                                             state_r != ST_IDLE};
        uep_pkg::REG_RDATA:  reg_rdata_o <= rdata_r;
        default:             reg_rdata_o <= 8'h00;
      endcase
    end
  end

  a_pulse_high_only_hv: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    select_program_strobe_o && gate_n_o && mem_data_oe_o |-> vpp_high_o)
    else $error("program pulse without high supply");
  a_pulse_data_driven: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(select_program_strobe_o) && vpp_high_o |-> $past(mem_data_oe_o))
    else $error("pulse before data stable");
  a_pulse_not_early_end: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && state_r == ST_PULSE && cnt_r > 21'h000001 |=> state_r == ST_PULSE)
    else $error("pulse ended early");
  a_pulse_gate_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mem_data_oe_o |-> gate_n_o)
    else $error("data driven with gate low");
  a_read_no_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !gate_n_o |-> !mem_data_oe_o && !select_program_strobe_o)
    else $error("contention during read");
  a_setup_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && state_r == ST_PSETUP |=> !select_program_strobe_o)
    else $error("strobe high during setup");
  a_refuse_no_hv: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && go && state_r == ST_IDLE && go_cmd == uep_pkg::CMD_PROGRAM && !hv_req_r
    |=> refuse_r && state_r == ST_IDLE)
    else $error("program started at low supply");
  a_read_sample: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && state_r == ST_RWAIT && cnt_done |=> rdata_r == $past(mem_data_i))
    else $error("read data not captured");
  c_program: cover property (@(posedge clk_sys_i) state_r == ST_PULSE ##1 state_r == ST_PHOLD);
  c_verify_ok: cover property (@(posedge clk_sys_i) cmd_r == uep_pkg::CMD_VERIFY && !mism_r
    && state_r == ST_RWAIT ##1 state_r == ST_IDLE);
  c_refuse: cover property (@(posedge clk_sys_i) $rose(refuse_r));
endmodule

// ==== shared/uep_pkg.sv ====
// Package for the EPROM programmer controller: register map, timing, commands.
// Assumes a 25 MHz system clock.
package uep_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned ADDR_W          = 11;
  localparam int unsigned DATA_W          = 8;
  // Register offsets of the controller's own map
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_ADDR        = 4'h1;
  localparam logic [3:0]  REG_WDATA       = 4'h2;
  localparam logic [3:0]  REG_STATUS      = 4'h3;
  localparam logic [3:0]  REG_RDATA       = 4'h4;
  // Control field positions
  localparam int unsigned CTRL_GO_BIT     = 0;
  localparam int unsigned CTRL_CMD_LSB    = 1;
  localparam int unsigned CTRL_HV_BIT     = 3;
  // Status field positions
  localparam int unsigned ST_BUSY_BIT     = 0;
  localparam int unsigned ST_HV_BIT       = 1;
  localparam int unsigned ST_MISM_BIT     = 2;
  localparam int unsigned ST_REFUSE_BIT   = 3;
  localparam int unsigned ST_ZERO_BIT     = 4;
  // Commands
  localparam logic [1:0]  CMD_READ        = 2'h0;
  localparam logic [1:0]  CMD_PROGRAM     = 2'h1;
  localparam logic [1:0]  CMD_VERIFY      = 2'h2;
  // Times
  localparam int unsigned PULSE_MIN_MS    = 45;
  localparam int unsigned PULSE_NOM_MS    = 50;
  localparam int unsigned PULSE_MAX_MS    = 55;
  localparam int unsigned SETUP_US        = 2;
  localparam int unsigned ACCESS_NS       = 450;
  localparam int unsigned PULSE_NOM_CYC   = PULSE_NOM_MS * (CLK_HZ / 1000);
  localparam int unsigned SETUP_CYC       = (SETUP_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned ACCESS_CYC      = (ACCESS_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W           = 21;
  // Reset values
  localparam logic [7:0]  RST_DATA        = 8'hff;
  localparam logic [10:0] RST_ADDR        = 11'h000;
endpackage

// ==== testbench/uep_eprom_model.sv ====
// Behavioural 2048 x 8 UV EPROM facing the controller's pins.
// Assumes the bench resolves the shared data wire and feeds it to data_i.
module uep_eprom_model (
  input  wire logic [10:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        strobe_i,
  input  wire logic        gate_n_i,
  input  wire logic        vpp_high_i,
  output logic      [7:0]  data_o,
  output logic             data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem_r [2048];
  logic [7:0]  last_r;
  logic [7:0]  pd;
  logic [10:0] pa;
  logic        armed;
  logic        oe_late;
  initial begin
    foreach (mem_r[i]) mem_r[i] = 8'hff;
    last_r = 8'h00;
    armed  = 1'b0;
  end
  // Drive only when selected and gated; otherwise a changed level
  assign data_oe_o = !strobe_i && !gate_n_i;
  // Byte valid only an access time after select and gate have fallen
  assign #(uep_pkg::ACCESS_NS) oe_late = data_oe_o;
  assign data_o    = (data_oe_o && oe_late) ? mem_r[addr_i] : ~last_r;
  always @(data_o or oe_late) if (data_oe_o && oe_late) last_r = data_o;
  always @(posedge strobe_i) begin
    armed = vpp_high_i && gate_n_i;
    pa    = addr_i;
    pd    = data_i;
  end
  // Bits only clear; any order of locations
  always @(negedge strobe_i) begin
    if (armed && vpp_high_i && gate_n_i) mem_r[pa] = mem_r[pa] & pd;
    armed = 1'b0;
  end
endmodule

// ==== testbench/uep_ctrl_tb.sv ====
// Self-checking bench for the EPROM controller with a behavioural EPROM.
// Assumes a shortened program pulse of P cycles.
module uep_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 20;
  logic clk_sys_i = 0, rst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, rd_d = 0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, mdo, edo, bus, d1, d2, st;
  logic [10:0] wal, pa;
  logic        moe, eoe, strobe, gate_n, vpp;
  logic [16:0] lf = 17'h11835;
  logic [15:0] q [$];
  int          errors = 0, cmp_count = 0, hi_cnt = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  assign bus = moe ? mdo : edo;
  uep_ctrl #(.PULSE_CYC(P)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .word_address_lines_o(wal),
    .mem_data_i(bus), .mem_data_o(mdo), .mem_data_oe_o(moe),
    .select_program_strobe_o(strobe), .gate_n_o(gate_n), .vpp_high_o(vpp));
  uep_eprom_model mem_u (.addr_i(wal), .data_i(bus), .strobe_i(strobe), .gate_n_i(gate_n),
    .vpp_high_i(vpp), .data_o(edo), .data_oe_o(eoe));
  function automatic logic [16:0] nxt(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1; q.push_back({e, m});
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic run(input logic [10:0] a, input logic [7:0] d, input logic [7:0] c);
    wr(uep_pkg::REG_ADDR, a[7:0]);
    wr(4'h3, {5'h00, a[10:8]});
    wr(uep_pkg::REG_WDATA, d);
    wr(uep_pkg::REG_CTRL, c & 8'hfe);
    wr(uep_pkg::REG_CTRL, c);
    for (int i = 0; i < 400; i++) begin
      rd(uep_pkg::REG_STATUS, 8'h00, 8'h00);
      #1 st = reg_rdata_o;
      if (st[uep_pkg::ST_BUSY_BIT] === 1'b0) break;
      if (i == 399) chk("busy", 0, 1);
    end
  endtask
  // Read results checked in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    logic [15:0] n;
    if (rd_d && q.size() > 0) begin
      n = q.pop_front();
      if (n[7:0] != 8'h00) chk("rdata", n[15:8], reg_rdata_o & n[7:0]);
    end
    rd_d <= reg_rd_i;
  end
  // Program pulse width and stable address while the pulse is high
  always @(posedge clk_sys_i) begin
    if (strobe === 1'b1 && vpp === 1'b1) begin
      if (hi_cnt == 0) pa = wal;
      hi_cnt <= hi_cnt + 1;
    end else if (hi_cnt != 0) begin
      chk("pulse", P, hi_cnt);
      chk("paddr", pa, wal);
      hi_cnt <= 0;
    end
  end
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(4'h7, 8'h00, 8'hff); // unmapped
    run(11'h7ff, 8'h00, 8'h01);
    rd(uep_pkg::REG_RDATA, 8'hff, 8'hff);
    run(11'h7ff, 8'h00, 8'h03);
    rd(uep_pkg::REG_STATUS, 8'h08, 8'h08);
    run(11'h7ff, 8'h00, 8'h01);
    rd(uep_pkg::REG_RDATA, 8'hff, 8'hff);
    for (int k = 0; k < 3; k++) begin
      lf = nxt(lf); d1 = lf[7:0]; lf = nxt(lf); d2 = lf[7:0]; lf = nxt(lf);
      run(lf[10:0], d1, 8'h0b);
      run(lf[10:0], d1, 8'h0d);
      rd(uep_pkg::REG_RDATA, d1, 8'hff);
      rd(uep_pkg::REG_STATUS, 8'h02, 8'h06);
      run(lf[10:0], d2, 8'h0b);
      rd(uep_pkg::REG_STATUS, {3'h0, |(d1 & ~d2), 4'h0}, 8'h10);
      run(lf[10:0], 8'h00, 8'h01);
      rd(uep_pkg::REG_RDATA, d1 & d2, 8'hff);
    end
    // Frozen while disabled: read data must hold
    ce_i <= 1'b0;
    rd(uep_pkg::REG_ADDR, d1 & d2, 8'hff);
    ce_i <= 1'b1;
    run(11'h7ff, 8'h5a, 8'h0b);
    run(11'h7ff, 8'h5b, 8'h0d);
    rd(uep_pkg::REG_STATUS, 8'h06, 8'h06);
    run(11'h7ff, 8'h5a, 8'h05);
    rd(uep_pkg::REG_STATUS, 8'h00, 8'h06);
    rd(uep_pkg::REG_RDATA, 8'h5a, 8'hff);
    repeat (3) @(posedge clk_sys_i);
    summarize();
  end
endmodule
